// File: testbench/gcsf_flags_props.sv
// Concurrent checks on the ports of the flag block.
`default_nettype none
module gcsf_flags_props import gcsf_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Watched ports.
  input wire logic softReset,
  input wire logic rxBitValid,
  input wire logic txBitTaken,
  input wire logic txActive_r,
  input wire logic txBit_r,
  input wire gcsf_sense_type sense,
  input wire logic [15:0] selfDischargeCount,
  input wire logic [7:0] primaryFlags_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_unused_zero: assert property (!(primaryFlags_r[2] || primaryFlags_r[0]))
    else $error("unused flag bit set");
  chk_overvolt_follow: assert property (primaryFlags_r[5] == $past(sense.cellOvervoltage))
    else $error("overvoltage flag wrong");
  chk_charge_follow: assert property (
    primaryFlags_r[7] == $past(sense.chargeValid && !sense.dischargeActive))
    else $error("charging flag wrong");
  chk_answer_start: assert property ($rose(txActive_r) |-> $past(rxBitValid))
    else $error("answer without eighth bit");
  chk_answer_stands: assert property (
    txActive_r && !txBitTaken |=> txActive_r && $stable(txBit_r))
    else $error("answer bit moved untaken");
  chk_empty_set: assert property (
    sense.cellBelowEmpty && !sense.emptyInhibit |=> primaryFlags_r[1])
    else $error("empty warning not set");
  chk_empty_latch: assert property (
    primaryFlags_r[1] && !sense.validChargeEvent || !primaryFlags_r[1] && sense.emptyInhibit
    |=> primaryFlags_r[1] == $past(primaryFlags_r[1]))
    else $error("empty warning changed");
  chk_soft_reset: assert property (softReset && !sense.dischargeActive |=>
    primaryFlags_r[6] && primaryFlags_r[4] && !primaryFlags_r[3])
    else $error("soft reset flags wrong");
  chk_sdc_clear: assert property (
    selfDischargeCount > 16'h1000 && !sense.dischargeActive |=> !primaryFlags_r[3])
    else $error("qualified discharge kept");
endmodule : gcsf_flags_props
bind gcsf_flags gcsf_flags_props gcsf_flags_props_inst (.clk(clk), .nrst(nrst),
  .softReset(softReset), .rxBitValid(rxBitValid), .txBitTaken(txBitTaken),
  .txActive_r(txActive_r), .txBit_r(txBit_r), .sense(sense),
  .selfDischargeCount(selfDischargeCount), .primaryFlags_r(primaryFlags_r));
`default_nettype wire

// File: testbench/gcsf_host_model.sv
// Host side of the serial port: sends bytes and takes answer bits.
`default_nettype none
module gcsf_host_model (
  // Clock.
  input wire logic clk,
  // Bits to the device.
  output logic rxBitValid,
  output logic rxBit,
  // Answer bits from the device.
  output logic txBitTaken,
  input wire logic txActive_r,
  input wire logic txBit_r
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxBitValid = 1'b0;
    rxBit = 1'b1;
    txBitTaken = 1'b0;
  end
  // A released data line shows the inverse of the last bit.
  task automatic send_byte(input logic [7:0] b, input int gap);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      rxBitValid = 1'b1;
      rxBit = b[i];
      @(negedge clk);
      rxBitValid = 1'b0;
      rxBit = ~b[i];
      repeat (gap) @(negedge clk);
    end
  endtask : send_byte
  task automatic read_byte(input logic [6:0] a, input int gap, output logic [7:0] d);
    int n;
    logic answered;
    n = 0;
    send_byte({1'b0, a}, gap);
    while (txActive_r !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    answered = (txActive_r === 1'b1);
    for (int i = 0; i < 8; i++) begin
      d[i] = txBit_r;
      txBitTaken = 1'b1;
      @(negedge clk);
      txBitTaken = 1'b0;
      repeat (gap + 1) @(negedge clk);
    end
    // A missing answer reads back as unknown so that the caller sees a mismatch.
    if (!answered) begin
      d = 8'hxx;
    end
  endtask : read_byte
endmodule : gcsf_host_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the flag block driven by a host model.
`default_nettype none
module tb_top import gcsf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic softReset = 1'b0;
  logic rxBitValid, rxBit, txBitTaken, txActive_r, txBit_r, usePrg = 1'b0;
  gcsf_sense_type sense = '0;
  logic [15:0] sdCount = 16'h0000, lfsr = 16'hD757;
  logic [7:0] avail = 8'h10, full = 8'h80, prg = 8'h40, flags, tg, rd;
  logic [3:0] temp = 4'h5, g;
  logic [4:0] leds;
  logic [1:0] band;
  int err_total = 0, comparisons = 0, cyc = 0;
  gcsf_flags #(.BLINK_HALF(4)) gcsf_flags_inst (.clk(clk), .nrst(nrst), .softReset(softReset),
    .rxBitValid(rxBitValid), .rxBit(rxBit), .txBitTaken(txBitTaken), .txActive_r(txActive_r),
    .txBit_r(txBit_r), .sense(sense), .selfDischargeCount(sdCount),
    .availableChargeHigh(avail), .learnedFullCapacity(full), .programmedFullCapacity(prg),
    .useProgrammedFull(usePrg), .temperatureCode(temp), .ledSegments_r(leds),
    .efficiencyBand_r(band), .primaryFlags_r(flags), .temperatureGauge_r(tg));
  gcsf_host_model gcsf_host_model_inst (.clk(clk), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .txBitTaken(txBitTaken), .txActive_r(txActive_r), .txBit_r(txBit_r));
  initial forever #4 clk = ~clk;
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic [3:0] gauge(logic [7:0] a, logic [7:0] f, logic [3:0] t);
    int q;
    q = a * 16;
    if (t < 2)
      q = q / 2;
    else if (t < 4)
      q = q * 3 / 4;
    q = (f == 8'h00) ? 0 : q / f;
    return (q > 15) ? 4'hF : q[3:0];
  endfunction : gauge
  function automatic logic [4:0] segs(logic [3:0] v);
    for (int i = 0; i < 5; i++) segs[i] = (v * 5 > 16 * i);
  endfunction : segs
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic pulse(int n, int b);
    repeat (n) begin
      sense[b] = 1'b1;
      tick(1);
      sense[b] = 1'b0;
      tick(1);
    end
  endtask : pulse
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    tick(16);
    nrst = 1'b1;
    tick(3);
    check(flags, 8'h50);
    gcsf_host_model_inst.send_byte(8'h81, 1);
    gcsf_host_model_inst.send_byte(8'hFF, 0);
    gcsf_host_model_inst.send_byte(8'h82, 0);
    gcsf_host_model_inst.send_byte(8'h00, 2);
    gcsf_host_model_inst.send_byte(8'h85, 0);
    gcsf_host_model_inst.send_byte(8'h3C, 0);
    gcsf_host_model_inst.read_byte(7'h01, 0, rd);
    check(rd, 8'h50);
    gcsf_host_model_inst.read_byte(7'h02, 2, rd);
    check(rd, 8'h52);
    gcsf_host_model_inst.read_byte(7'h7F, 1, rd);
    check(rd, 8'h00);
    check({7'h00, txActive_r}, 8'h00);
    $display("serial test done");
    sense.cellOvervoltage = 1'b1;
    sense.chargeValid = 1'b1;
    tick(2);
    check(flags, 8'hF0);
    sense.dischargeActive = 1'b1;
    sense.cellOvervoltage = 1'b0;
    sense.cellBelowEmpty = 1'b1;
    sense.emptyInhibit = 1'b1;
    tick(2);
    check(flags, 8'h50);
    sense.emptyInhibit = 1'b0;
    tick(3);
    check(flags, 8'h12);
    rd[0] = leds[0];
    tick(4);
    check({7'h00, leds[0]}, {7'h00, ~rd[0]});
    sense = '0;
    tick(2);
    check(flags, 8'h12);
    pulse(1, 2);
    check(flags, 8'h10);
    pulse(1, 0);
    check(flags, 8'h00);
    pulse(63, 2);
    check(flags, 8'h00);
    pulse(1, 2);
    check(flags, 8'h10);
    avail = full;
    sense.dischargeActive = 1'b1;
    tick(2);
    check(flags, 8'h18);
    sense.dischargeActive = 1'b0;
    sense.chargeValid = 1'b1;
    pulse(255, 1);
    check(flags, 8'h98);
    pulse(1, 1);
    check(flags, 8'h90);
    sense.chargeValid = 1'b0;
    sense.dischargeActive = 1'b1;
    tick(2);
    sense.dischargeActive = 1'b0;
    sdCount = 16'h1000;
    tick(2);
    check(flags, 8'h18);
    sdCount = 16'h1001;
    tick(2);
    check(flags, 8'h10);
    sdCount = 16'h0000;
    sense.dischargeActive = 1'b1;
    tick(2);
    sense.dischargeActive = 1'b0;
    avail = 8'h10;
    softReset = 1'b1;
    tick(1);
    softReset = 1'b0;
    tick(1);
    check(flags, 8'h50);
    avail = full;
    sense.dischargeActive = 1'b1;
    tick(2);
    check(flags, 8'h58);
    temp = 4'h3;
    sense.cellBelowEmpty = 1'b1;
    tick(3);
    check(flags, 8'h12);
    sense = '0;
    pulse(1, 2);
    sense.cellAboveMin = 1'b1;
    sense.regsCorrupt = 1'b1;
    tick(1);
    check(flags, 8'h50);
    tick(1);
    check(flags, 8'h10);
    sense = '0;
    $display("flag test done");
    for (int i = 0; i < 40; i++) begin
      temp = (i < 4) ? 4'(i) : 4'(rnd() % 13);
      avail = (i < 4) ? 8'h40 : 8'(rnd());
      full = (i < 4) ? 8'h80 : 8'(rnd());
      prg = (i % 5 == 0) ? 8'h00 : 8'(rnd());
      usePrg = (i < 4) ? 1'b0 : 1'(rnd() % 2);
      tick(4);
      g = gauge(avail, usePrg ? prg : full, temp);
      check(tg, {temp, g});
      check({6'h00, band}, (temp < 4) ? 8'h00 : (temp < 8) ? 8'h01 : 8'h02);
      check({3'h0, leds}, {3'h0, segs(g)});
    end
    $display("gauge test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// File: verilog/gcsf_defs.svh
// Constants of the gauge command and status flag block.
`ifndef GCSF_DEFS_SVH
`define GCSF_DEFS_SVH

`define GCSF_ADDR_PRIMARY_FLAGS 7'h01
`define GCSF_ADDR_TEMP_GAUGE 7'h02
`define GCSF_CMD_DIR_BIT 7
`define GCSF_FLAG_CHARGING 7
`define GCSF_FLAG_PACK_REPLACED 6
`define GCSF_FLAG_CELL_OVERVOLT 5
`define GCSF_FLAG_CAP_STALE 4
`define GCSF_FLAG_QUAL_DISCHARGE 3
`define GCSF_FLAG_EMPTY_WARNING 1
`define GCSF_FLAGS_RESET 8'h50
`define GCSF_STALE_CHARGES 8'h40
`define GCSF_CHARGE_CNT_MAX 8'hFF
`define GCSF_SDC_LIMIT 16'h1000
`define GCSF_QUAL_CHARGE_COUNTS 9'h100
`define GCSF_TEMP_ZERO_C 4'h4
`define GCSF_TEMP_MINUS20_C 4'h2
`define GCSF_GAUGE_MAX 4'hF
`define GCSF_CLK_PERIOD_NS 8
`define GCSF_BLINK_PERIOD_NS 250000000
`define GCSF_BLINK_HALF_CYCLES ((`GCSF_BLINK_PERIOD_NS / 2) / `GCSF_CLK_PERIOD_NS)

`endif

// File: verilog/gcsf_flags.sv
// Command decode, primary flags and temperature/gauge register of the charge monitor.
`default_nettype none
`include "gcsf_defs.svh"
module gcsf_flags import gcsf_pkg::*; #(
  parameter int unsigned BLINK_HALF = `GCSF_BLINK_HALF_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  input wire logic softReset,
  // Serial bits in, one strobe per bit.
  input wire logic rxBitValid,
  input wire logic rxBit,
  // Serial bits out, host acknowledges each bit.
  input wire logic txBitTaken,
  output logic txActive_r,
  output logic txBit_r,
  // Measured conditions.
  input wire gcsf_sense_type sense,
  input wire logic [15:0] selfDischargeCount,
  input wire logic [7:0] availableChargeHigh,
  input wire logic [7:0] learnedFullCapacity,
  input wire logic [7:0] programmedFullCapacity,
  input wire logic useProgrammedFull,
  input wire logic [3:0] temperatureCode,
  // Results.
  output logic [4:0] ledSegments_r,
  output logic [1:0] efficiencyBand_r,
  output logic [7:0] primaryFlags_r,
  output logic [7:0] temperatureGauge_r
);
  generate
    if (BLINK_HALF < 1) begin : gBadBlink
      $error("BLINK_HALF must be at least one cycle");
    end
  endgenerate

  function automatic logic [4:0] segmentsOf(input logic [3:0] g);
    logic [6:0] scaled;
    logic [4:0] s;
    scaled = {3'b000, g} * 7'd5;
    for (int i = 0; i < 5; i++) begin
      s[i] = scaled > 7'(i * 16);
    end
    return s;
  endfunction : segmentsOf

  // Command and serial path state.
  gcsf_state_type state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bitCount_r, bitCount_nxt;
  logic txActive_nxt;
  logic txBit_nxt;
  gcsf_cmd_type cmd;
  logic [7:0] rxByte;
  logic byteDone;

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitCount_nxt = bitCount_r;
    txActive_nxt = txActive_r;
    txBit_nxt = txBit_r;
    rxByte = {rxBit, shift_r[7:1]};
    cmd = gcsf_cmd_type'(rxByte);
    byteDone = rxBitValid && (bitCount_r == 3'd7);
    case (state_r)
      GCSF_CMD: begin
        if (rxBitValid) begin
          shift_nxt = rxByte;
          bitCount_nxt = bitCount_r + 3'd1;
        end
        if (byteDone) begin
          if (cmd.writeNotRead) begin
            state_nxt = GCSF_DATA;
          end else begin
            case (cmd.registerSelect)
              `GCSF_ADDR_PRIMARY_FLAGS: shift_nxt = primaryFlags_r;
              `GCSF_ADDR_TEMP_GAUGE: shift_nxt = temperatureGauge_r;
              default: shift_nxt = 8'h00;
            endcase
            txBit_nxt = shift_nxt[0];
            txActive_nxt = 1'b1;
            state_nxt = GCSF_SEND;
          end
        end
      end
      GCSF_DATA: begin
        if (rxBitValid) begin
          bitCount_nxt = bitCount_r + 3'd1;
        end
        // Both mapped registers are read-only, so every data byte is dropped.
        if (byteDone) begin
          state_nxt = GCSF_CMD;
        end
      end
      GCSF_SEND: begin
        if (txBitTaken) begin
          shift_nxt = {1'b0, shift_r[7:1]};
          txBit_nxt = shift_r[1];
          bitCount_nxt = bitCount_r + 3'd1;
          if (bitCount_r == 3'd7) begin
            txActive_nxt = 1'b0;
            txBit_nxt = 1'b0;
            state_nxt = GCSF_CMD;
          end
        end
      end
      default: begin
        state_nxt = GCSF_CMD;
        bitCount_nxt = 3'd0;
        txActive_nxt = 1'b0;
      end
    endcase
    if (softReset) begin
      state_nxt = GCSF_CMD;
      bitCount_nxt = 3'd0;
      txActive_nxt = 1'b0;
      txBit_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= GCSF_CMD;
      shift_r <= 8'h00;
      bitCount_r <= 3'd0;
      txActive_r <= 1'b0;
      txBit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bitCount_r <= bitCount_nxt;
      txActive_r <= txActive_nxt;
      txBit_r <= txBit_nxt;
    end
  end

  // Flag state and its event history.
  logic [7:0] primaryFlags_nxt;
  logic [7:0] chargeCount_r, chargeCount_nxt;
  logic [8:0] qualCharge_r, qualCharge_nxt;
  logic cellAboveMinPrev_r;
  logic dischargePrev_r;
  logic atFull;
  logic cold;

  always_comb begin
    primaryFlags_nxt = primaryFlags_r;
    chargeCount_nxt = chargeCount_r;
    qualCharge_nxt = qualCharge_r;
    atFull = availableChargeHigh == learnedFullCapacity;
    cold = temperatureCode < `GCSF_TEMP_ZERO_C;
    primaryFlags_nxt[`GCSF_FLAG_CHARGING] = sense.chargeValid && !sense.dischargeActive;
    primaryFlags_nxt[`GCSF_FLAG_CELL_OVERVOLT] = sense.cellOvervoltage;
    if ((atFull && !sense.dischargeActive) ||
        (sense.dischargeActive && primaryFlags_r[`GCSF_FLAG_EMPTY_WARNING])) begin
      primaryFlags_nxt[`GCSF_FLAG_PACK_REPLACED] = 1'b0;
    end
    if (sense.cellAboveMin && !cellAboveMinPrev_r && sense.regsCorrupt) begin
      primaryFlags_nxt[`GCSF_FLAG_PACK_REPLACED] = 1'b1;
    end
    if (sense.validChargeEvent && chargeCount_r != `GCSF_CHARGE_CNT_MAX) begin
      chargeCount_nxt = chargeCount_r + 8'h01;
    end
    if (sense.learnedUpdate) begin
      chargeCount_nxt = 8'h00;
      primaryFlags_nxt[`GCSF_FLAG_CAP_STALE] = 1'b0;
      primaryFlags_nxt[`GCSF_FLAG_QUAL_DISCHARGE] = 1'b0;
    end
    // The 64th charge sets the stale flag even when an update clears it in the same cycle.
    if (sense.validChargeEvent && (chargeCount_r + 8'h01) == `GCSF_STALE_CHARGES) begin
      primaryFlags_nxt[`GCSF_FLAG_CAP_STALE] = 1'b1;
    end
    if (sense.chargeCountPulse && sense.chargeValid &&
        qualCharge_r != `GCSF_QUAL_CHARGE_COUNTS) begin
      qualCharge_nxt = qualCharge_r + 9'h001;
    end
    if (qualCharge_nxt == `GCSF_QUAL_CHARGE_COUNTS) begin
      primaryFlags_nxt[`GCSF_FLAG_QUAL_DISCHARGE] = 1'b0;
    end
    if (selfDischargeCount > `GCSF_SDC_LIMIT) begin
      primaryFlags_nxt[`GCSF_FLAG_QUAL_DISCHARGE] = 1'b0;
    end
    if (sense.validChargeEvent) begin
      primaryFlags_nxt[`GCSF_FLAG_EMPTY_WARNING] = 1'b0;
    end
    if (sense.cellBelowEmpty && !sense.emptyInhibit) begin
      primaryFlags_nxt[`GCSF_FLAG_EMPTY_WARNING] = 1'b1;
      if (!primaryFlags_r[`GCSF_FLAG_EMPTY_WARNING] && cold) begin
        primaryFlags_nxt[`GCSF_FLAG_QUAL_DISCHARGE] = 1'b0;
      end
    end
    if (sense.dischargeActive && !dischargePrev_r && atFull) begin
      primaryFlags_nxt[`GCSF_FLAG_QUAL_DISCHARGE] = 1'b1;
      qualCharge_nxt = 9'h000;
    end
    if (softReset) begin
      primaryFlags_nxt[`GCSF_FLAG_PACK_REPLACED] = 1'b1;
      primaryFlags_nxt[`GCSF_FLAG_CAP_STALE] = 1'b1;
      primaryFlags_nxt[`GCSF_FLAG_QUAL_DISCHARGE] = 1'b0;
      chargeCount_nxt = 8'h00;
    end
    primaryFlags_nxt[2] = 1'b0;
    primaryFlags_nxt[0] = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      primaryFlags_r <= `GCSF_FLAGS_RESET;
      chargeCount_r <= 8'h00;
      qualCharge_r <= 9'h000;
      cellAboveMinPrev_r <= 1'b0;
      dischargePrev_r <= 1'b0;
    end else begin
      primaryFlags_r <= primaryFlags_nxt;
      chargeCount_r <= chargeCount_nxt;
      qualCharge_r <= qualCharge_nxt;
      cellAboveMinPrev_r <= sense.cellAboveMin;
      dischargePrev_r <= sense.dischargeActive;
    end
  end

  // Temperature, gauge and display.
  logic [3:0] gauge;
  logic [7:0] fullReference;
  logic [31:0] blinkCount_r, blinkCount_nxt;
  logic blinkPhase_r, blinkPhase_nxt;
  logic [4:0] ledSegments_nxt;
  logic [1:0] efficiencyBand_nxt;
  logic [7:0] temperatureGauge_nxt;

  assign fullReference = useProgrammedFull ? programmedFullCapacity : learnedFullCapacity;

  gcsf_gauge uGauge (
    .clk(clk),
    .nrst(nrst),
    .availableChargeHigh(availableChargeHigh),
    .fullReference(fullReference),
    .temperatureCode(temperatureCode),
    .gauge_r(gauge)
  );

  always_comb begin
    temperatureGauge_nxt = {temperatureCode, gauge};
    // Band 0 below 0 C, band 1 from 0 C to below 40 C, band 2 from 40 C.
    if (temperatureCode < `GCSF_TEMP_ZERO_C) begin
      efficiencyBand_nxt = 2'd0;
    end else if (temperatureCode < 4'h8) begin
      efficiencyBand_nxt = 2'd1;
    end else begin
      efficiencyBand_nxt = 2'd2;
    end
    blinkCount_nxt = blinkCount_r + 32'd1;
    blinkPhase_nxt = blinkPhase_r;
    if (blinkCount_r >= BLINK_HALF - 1) begin
      blinkCount_nxt = 32'd0;
      blinkPhase_nxt = !blinkPhase_r;
    end
    ledSegments_nxt = segmentsOf(gauge);
    if (primaryFlags_r[`GCSF_FLAG_EMPTY_WARNING]) begin
      ledSegments_nxt[0] = blinkPhase_r;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      temperatureGauge_r <= 8'h00;
      efficiencyBand_r <= 2'd0;
      blinkCount_r <= 32'd0;
      blinkPhase_r <= 1'b0;
      ledSegments_r <= 5'h00;
    end else begin
      temperatureGauge_r <= temperatureGauge_nxt;
      efficiencyBand_r <= efficiencyBand_nxt;
      blinkCount_r <= blinkCount_nxt;
      blinkPhase_r <= blinkPhase_nxt;
      ledSegments_r <= ledSegments_nxt;
    end
  end
endmodule : gcsf_flags
`default_nettype wire

// File: verilog/gcsf_gauge.sv
// Available capacity in sixteenths, with cold temperature derating.
`default_nettype none
`include "gcsf_defs.svh"
module gcsf_gauge import gcsf_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Inputs to the calculation.
  input wire logic [7:0] availableChargeHigh,
  input wire logic [7:0] fullReference,
  input wire logic [3:0] temperatureCode,
  // Result.
  output logic [3:0] gauge_r
);
  logic [3:0] gauge_nxt;
  logic [11:0] scaled;
  logic [11:0] quotient;

  always_comb begin
    scaled = {availableChargeHigh, 4'h0};
    if (temperatureCode < `GCSF_TEMP_MINUS20_C) begin
      scaled = {1'b0, scaled[11:1]};
    end else if (temperatureCode < `GCSF_TEMP_ZERO_C) begin
      scaled = scaled - {2'b00, scaled[11:2]};
    end
    quotient = (fullReference == 8'h00) ? 12'h000 : scaled / {4'h0, fullReference};
    gauge_nxt = (quotient > {8'h00, `GCSF_GAUGE_MAX}) ? `GCSF_GAUGE_MAX : quotient[3:0];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gauge_r <= 4'h0;
    end else begin
      gauge_r <= gauge_nxt;
    end
  end
endmodule : gcsf_gauge
`default_nettype wire

// File: verilog/gcsf_pkg.sv
// Types of the gauge command and status flag block.
`default_nettype none
package gcsf_pkg;

  typedef struct packed {
    logic writeNotRead;
    logic [6:0] registerSelect;
  } gcsf_cmd_type;

  typedef struct packed {
    logic chargeValid;
    logic dischargeActive;
    logic cellAboveMin;
    logic regsCorrupt;
    logic cellOvervoltage;
    logic cellBelowEmpty;
    logic emptyInhibit;
    logic validChargeEvent;
    logic chargeCountPulse;
    logic learnedUpdate;
  } gcsf_sense_type;

  typedef enum logic [1:0] {
    GCSF_CMD,
    GCSF_DATA,
    GCSF_SEND
  } gcsf_state_type;

endpackage : gcsf_pkg
`default_nettype wire
